// ---- verilog/mdt_decode.sv ----
// Instruction decode, execution and cycle timing of the 8-bit core
`timescale 1ns/1ps

// Overview of operation
// [RULE_01] Instruction word is 13 bits, opcode plus operands
// [RULE_02] Instruction cycle is two clocks, normally one cycle
// [RULE_03] Writes to program counter take two cycles
// [RULE_04] Call, jump, returns, taken skips take two cycles
// [RULE_05] Any register bit can be set, cleared, tested
// [RULE_06] I/O registers use ordinary register instructions
// [RULE_07] Bank select bits 6 and 7 choose bank
// [RULE_08] Bit field selects bit for bit operations
// [RULE_09] Literals are 8 bits data, 10 bits targets
// [RULE_10] Sleep and watchdog clear reset counter, update flags
// [RULE_11] Return from interrupt pops and enables interrupts
// [RULE_12] Table adds accumulator to PC low, flags updated
// [RULE_13] Decrement-skip writes register, skips on zero
// [RULE_14] Decrement-to-accumulator-skip leaves register, skips zero
// [RULE_15] Add to register stores sum, updates flags
// [RULE_16] Register field picks one register to use
// [RULE_17] Rotate right through carry via bit 7
// [RULE_18] Second cycle discards prefetched word as no-op
module mdt_decode
	import mdt_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [INSTR_W-1:0] i_instr,
	input wire logic [ADDR_W-1:0] i_sw_addr,
	input wire logic [DATA_W-1:0] i_sw_wdata,
	input wire logic i_sw_wr,
	input wire logic i_sw_rd,
	output logic [DATA_W-1:0] o_sw_rdata,
	output logic [PC_W-1:0] o_pc,
	output logic [DATA_W-1:0] o_acc,
	output logic o_exec,
	output logic o_two_cycle,
	output logic o_sleep,
	output logic o_wdt_clear,
	output logic o_int_en
);

	// ************************************************************
	// State
	// ************************************************************
	mdt_phase_t phase_r;
	logic [DATA_W-1:0] rf_mem [RF_DEPTH];
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	logic [SP_W-1:0] sp_r;
	logic [PC_W-1:0] pc_r;
	logic [DATA_W-1:0] acc_r;
	logic [DATA_W-1:0] status_r;
	logic [DATA_W-1:0] bank_r;
	logic flush_r;
	logic exec_r;
	logic wdt_clear_r;
	logic int_en_r;
	logic [DATA_W-1:0] sw_rdata_r;

	// ************************************************************
	// Operand fields
	// ************************************************************
	logic [RSEL_W-1:0] rsel;
	logic [2:0] bsel;
	logic [DATA_W-1:0] k8;
	logic [PC_W-1:0] k10;
	logic [ADDR_W-1:0] eff;
	logic [DATA_W-1:0] rv;
	logic [DATA_W-1:0] bmask;
	logic exec;

	assign rsel = i_instr[RSEL_W-1:0]; // [RULE_16]
	assign bsel = i_instr[BIT_LSB+2:BIT_LSB]; // [RULE_08]
	assign k8 = i_instr[DATA_W-1:0]; // [RULE_09]
	assign k10 = i_instr[PC_W-1:0]; // [RULE_09]
	assign bmask = 8'h01 << bsel; // [RULE_05]
	// Low sixteen registers are shared by every bank
	assign eff = (rsel[5:4] == 2'b00) ? {2'b00, rsel} :
		{bank_r[BANK_HI:BANK_LO], rsel}; // [RULE_07]

	function automatic logic [DATA_W-1:0] rd_reg(
		input logic [ADDR_W-1:0] a
	);
		// Ports and peripherals live in the same file [RULE_06]
		if (a == IDX_PC) begin
			rd_reg = pc_r[DATA_W-1:0];
		end else if (a == IDX_STATUS) begin
			rd_reg = status_r;
		end else if (a == IDX_BANK) begin
			rd_reg = bank_r;
		end else begin
			rd_reg = rf_mem[a];
		end
	endfunction

	assign rv = rd_reg(eff);
	// Execute on the second clock of the cycle unless flushed [RULE_02]
	assign exec = (phase_r == PH_SECOND) && !flush_r;

	// ************************************************************
	// Arithmetic
	// ************************************************************
	logic is_tbl;
	logic [DATA_W-1:0] opb;
	logic [8:0] add_s;
	logic [4:0] add_h;
	logic [8:0] sub_s;
	logic [4:0] sub_h;

	assign is_tbl = (i_instr == OP_TABLE);
	// The counter still points at the table instruction, so one is added before the sum
	assign opb = is_tbl ? (pc_r[DATA_W-1:0] + 8'h01) :
		(i_instr[12] ? k8 : rv); // [RULE_12]
	assign add_s = {1'b0, acc_r} + {1'b0, opb};
	assign add_h = {1'b0, acc_r[3:0]} + {1'b0, opb[3:0]};
	// Carry is set when no borrow occurs
	assign sub_s = {1'b0, opb} + {1'b0, ~acc_r} + 9'h001;
	assign sub_h = {1'b0, opb[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;

	// ************************************************************
	// Decode
	// ************************************************************
	logic [DATA_W-1:0] res;
	logic dst, wr_a, wr_r, fz, fcd, fc;
	logic c_n, dc_n, skip, jump, push, pop;
	logic sleep_go, wdt_go, ie_set, ie_clr;
	logic [PC_W-1:0] tgt;
	logic pc_wr;

	always_comb begin
		res = 8'h00;
		dst = 1'b0;
		wr_a = 1'b0;
		wr_r = 1'b0;
		fz = 1'b0;
		fcd = 1'b0;
		fc = 1'b0;
		c_n = status_r[ST_C];
		dc_n = status_r[ST_DC];
		skip = 1'b0;
		jump = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		sleep_go = 1'b0;
		wdt_go = 1'b0;
		ie_set = 1'b0;
		ie_clr = 1'b0;
		tgt = stack_mem[sp_r - 3'h1];
		casez (i_instr) // [RULE_01]
		OP_SLEEP: begin
			sleep_go = 1'b1; // [RULE_10]
			wdt_go = 1'b1;
		end
		OP_WDT_CLR: wdt_go = 1'b1; // [RULE_10]
		OP_ENI: ie_set = 1'b1;
		OP_DISI: ie_clr = 1'b1;
		OP_RET: begin
			pop = 1'b1; // [RULE_11]
			jump = 1'b1;
		end
		OP_RETURN_FROM_INTERRUPT: begin
			pop = 1'b1; // [RULE_11]
			jump = 1'b1;
			ie_set = 1'b1;
		end
		OP_TABLE: begin
			res = add_s[7:0]; // [RULE_12]
			c_n = add_s[8];
			dc_n = add_h[4];
			fz = 1'b1;
			fcd = 1'b1;
		end
		OP_CLRA: begin
			wr_a = 1'b1;
			fz = 1'b1;
		end
		OP_SWINT: begin
			push = 1'b1;
			jump = 1'b1;
			tgt = INT_VECTOR;
		end
		13'b0_0000_01??_????: begin
			res = acc_r;
			wr_r = 1'b1;
		end
		13'b0_0000_11??_????: begin
			wr_r = 1'b1;
			fz = 1'b1;
		end
		13'b0_0001_0???_????: begin
			res = sub_s[7:0];
			c_n = sub_s[8];
			dc_n = sub_h[4];
			dst = 1'b1;
			fz = 1'b1;
			fcd = 1'b1;
		end
		13'b0_0001_1???_????: begin
			res = rv - 8'h01;
			dst = 1'b1;
			fz = 1'b1;
		end
		13'b0_0010_0???_????: begin
			res = acc_r | rv;
			dst = 1'b1;
			fz = 1'b1;
		end
		13'b0_0010_1???_????: begin
			res = acc_r & rv;
			dst = 1'b1;
			fz = 1'b1;
		end
		13'b0_0011_0???_????: begin
			res = acc_r ^ rv;
			dst = 1'b1;
			fz = 1'b1;
		end
		13'b0_0011_1???_????: begin
			res = add_s[7:0]; // [RULE_15]
			c_n = add_s[8];
			dc_n = add_h[4];
			dst = 1'b1;
			fz = 1'b1;
			fcd = 1'b1;
		end
		13'b0_0100_0???_????: begin
			res = rv;
			dst = 1'b1;
			fz = 1'b1;
		end
		13'b0_0100_1???_????: begin
			res = ~rv;
			dst = 1'b1;
			fz = 1'b1;
		end
		13'b0_0101_0???_????: begin
			res = rv + 8'h01;
			dst = 1'b1;
			fz = 1'b1;
		end
		13'b0_0101_1???_????: begin
			// Flags untouched; A or R chosen by bit 6 [RULE_13] [RULE_14]
			res = rv - 8'h01;
			dst = 1'b1;
			skip = (res == 8'h00);
		end
		13'b0_0110_0???_????: begin
			res = {status_r[ST_C], rv[7:1]}; // [RULE_17]
			c_n = rv[0];
			dst = 1'b1;
			fc = 1'b1;
		end
		13'b0_0110_1???_????: begin
			res = {rv[6:0], status_r[ST_C]};
			c_n = rv[7];
			dst = 1'b1;
			fc = 1'b1;
		end
		13'b0_0111_0???_????: begin
			res = {rv[3:0], rv[7:4]};
			dst = 1'b1;
		end
		13'b0_0111_1???_????: begin
			res = rv + 8'h01;
			dst = 1'b1;
			skip = (res == 8'h00);
		end
		13'b0_100?_????_????: begin
			res = rv & ~bmask; // [RULE_05]
			wr_r = 1'b1;
		end
		13'b0_101?_????_????: begin
			res = rv | bmask; // [RULE_05]
			wr_r = 1'b1;
		end
		13'b0_110?_????_????: skip = ((rv & bmask) == 8'h00);
		13'b0_111?_????_????: skip = ((rv & bmask) != 8'h00);
		13'b1_00??_????_????: begin
			push = 1'b1; // [RULE_04]
			jump = 1'b1;
			tgt = k10;
		end
		13'b1_01??_????_????: begin
			jump = 1'b1; // [RULE_04]
			tgt = k10;
		end
		13'b1_1000_????_????: begin
			res = k8;
			wr_a = 1'b1;
		end
		13'b1_1001_????_????: begin
			res = acc_r | k8;
			wr_a = 1'b1;
			fz = 1'b1;
		end
		13'b1_1010_????_????: begin
			res = acc_r & k8;
			wr_a = 1'b1;
			fz = 1'b1;
		end
		13'b1_1011_????_????: begin
			res = acc_r ^ k8;
			wr_a = 1'b1;
			fz = 1'b1;
		end
		13'b1_1100_????_????: begin
			res = k8;
			wr_a = 1'b1;
			pop = 1'b1;
			jump = 1'b1;
		end
		13'b1_1101_????_????: begin
			res = sub_s[7:0];
			c_n = sub_s[8];
			dc_n = sub_h[4];
			wr_a = 1'b1;
			fz = 1'b1;
			fcd = 1'b1;
		end
		13'b1_1111_????_????: begin
			res = add_s[7:0];
			c_n = add_s[8];
			dc_n = add_h[4];
			wr_a = 1'b1;
			fz = 1'b1;
			fcd = 1'b1;
		end
		default: res = 8'h00;
		endcase
		wr_a = wr_a | (dst & ~i_instr[6]);
		wr_r = wr_r | (dst & i_instr[6]);
	end

	assign pc_wr = is_tbl || (wr_r && eff == IDX_PC); // [RULE_03]

	// ************************************************************
	// Cycle phase
	// ************************************************************
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			phase_r <= PH_FIRST;
		end else begin
			unique case (phase_r)
			PH_FIRST: phase_r <= PH_SECOND;
			// Oscillator stopped; only reset wakes the core
			PH_SECOND: phase_r <= (exec && sleep_go) ? PH_STOP : PH_FIRST;
			PH_STOP: phase_r <= PH_STOP;
			default: phase_r <= PH_FIRST;
			endcase
		end
	end

	// ************************************************************
	// Program counter, stack and flush
	// ************************************************************
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pc_r <= RST_PC;
			sp_r <= '0;
			flush_r <= 1'b0;
		end else if (phase_r == PH_SECOND) begin
			if (flush_r) begin
				flush_r <= 1'b0; // [RULE_18]
			end else begin
				flush_r <= jump | skip | pc_wr; // [RULE_03] [RULE_04]
				if (push) begin
					stack_mem[sp_r] <= pc_r + 10'h001;
					sp_r <= sp_r + 3'h1;
				end
				if (pop) begin
					sp_r <= sp_r - 3'h1;
				end
				// PC bits 9..8 survive a low-byte write [RULE_12]
				if (jump) begin
					pc_r <= tgt;
				end else if (pc_wr) begin
					pc_r <= {pc_r[PC_W-1:DATA_W], res};
				end else if (skip) begin
					pc_r <= pc_r + 10'h002;
				end else if (!sleep_go) begin
					pc_r <= pc_r + 10'h001;
				end
			end
		end
	end

	// ************************************************************
	// Accumulator
	// ************************************************************
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_r <= RST_ACC;
		end else if (exec && wr_a) begin
			acc_r <= res; // [RULE_14]
		end
	end

	// ************************************************************
	// Register file, status and bank select
	// ************************************************************
	// Core writes win over a software write in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (exec && wr_r && eff > IDX_BANK) begin
			rf_mem[eff] <= res; // [RULE_13] [RULE_15] [RULE_06]
		end else if (i_sw_wr && i_sw_addr > IDX_BANK) begin
			rf_mem[i_sw_addr] <= i_sw_wdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bank_r <= RST_BANK;
		end else if (exec && wr_r && eff == IDX_BANK) begin
			bank_r <= res; // [RULE_07]
		end else if (i_sw_wr && i_sw_addr == IDX_BANK) begin
			bank_r <= i_sw_wdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			status_r <= RST_STATUS;
		end else if (exec) begin
			if (wr_r && eff == IDX_STATUS) begin
				status_r <= res;
			end
			// Flag updates override a plain write to status
			if (fz) begin
				status_r[ST_Z] <= (res == 8'h00);
			end
			if (fcd || fc) begin
				status_r[ST_C] <= c_n;
			end
			if (fcd) begin
				status_r[ST_DC] <= dc_n;
			end
			if (wdt_go) begin
				status_r[ST_T] <= 1'b1; // [RULE_10]
				status_r[ST_P] <= ~sleep_go;
			end
		end else if (i_sw_wr && i_sw_addr == IDX_STATUS) begin
			status_r <= i_sw_wdata;
		end
	end

	// ************************************************************
	// Control outputs and software read port
	// ************************************************************
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			exec_r <= 1'b0;
			wdt_clear_r <= 1'b0;
			int_en_r <= 1'b0;
		end else begin
			exec_r <= exec;
			wdt_clear_r <= exec & wdt_go; // [RULE_10]
			if (exec && ie_set) begin
				int_en_r <= 1'b1; // [RULE_11]
			end else if (exec && ie_clr) begin
				int_en_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sw_rdata_r <= 8'h00;
		end else begin
			sw_rdata_r <= i_sw_rd ? rd_reg(i_sw_addr) : 8'h00;
		end
	end

	assign o_sw_rdata = sw_rdata_r;
	assign o_pc = pc_r;
	assign o_acc = acc_r;
	assign o_exec = exec_r;
	assign o_two_cycle = flush_r;
	assign o_sleep = (phase_r == PH_STOP);
	assign o_wdt_clear = wdt_clear_r;
	assign o_int_en = int_en_r;

endmodule

// ---- verilog/mdt_pkg.sv ----
// Constants shared by the instruction decode and timing block
package mdt_pkg;

	// ************************************************************
	// Widths and sizes
	// ************************************************************
	localparam int INSTR_W = 13;
	localparam int PC_W = 10;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int RSEL_W = 6;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 3;
	localparam int RF_DEPTH = 256;
	localparam int OSC_PER_CYCLE = 2;

	// ************************************************************
	// Field positions in the instruction word and the bank select register
	// ************************************************************
	localparam int BIT_LSB = 6;
	localparam int BANK_LO = 6;
	localparam int BANK_HI = 7;

	// ************************************************************
	// Register indexes and status bit positions
	// ************************************************************
	localparam logic [ADDR_W-1:0] IDX_PC = 8'h02;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h03;
	localparam logic [ADDR_W-1:0] IDX_BANK = 8'h04;
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_P = 3;
	localparam int ST_T = 4;

	// ************************************************************
	// Reset values and interrupt vector
	// ************************************************************
	localparam logic [PC_W-1:0] RST_PC = 10'h000;
	localparam logic [DATA_W-1:0] RST_STATUS = 8'h18;
	localparam logic [DATA_W-1:0] RST_BANK = 8'h00;
	localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
	localparam logic [PC_W-1:0] INT_VECTOR = 10'h002;

	// ************************************************************
	// Fixed opcodes
	// ************************************************************
	localparam logic [INSTR_W-1:0] OP_SLEEP = 13'h0003;
	localparam logic [INSTR_W-1:0] OP_WDT_CLR = 13'h0004;
	localparam logic [INSTR_W-1:0] OP_ENI = 13'h0010;
	localparam logic [INSTR_W-1:0] OP_DISI = 13'h0011;
	localparam logic [INSTR_W-1:0] OP_RET = 13'h0012;
	localparam logic [INSTR_W-1:0] OP_RETURN_FROM_INTERRUPT = 13'h0013;
	localparam logic [INSTR_W-1:0] OP_TABLE = 13'h0020;
	localparam logic [INSTR_W-1:0] OP_CLRA = 13'h0080;
	localparam logic [INSTR_W-1:0] OP_SWINT = 13'h1e02;

	// Instruction cycle phases
	typedef enum logic [2:0] {
		PH_FIRST = 3'b001,
		PH_SECOND = 3'b010,
		PH_STOP = 3'b100
	} mdt_phase_t;

endpackage

// ---- testbench/mdt_pmem_model.sv ----
// Program memory model answering the core's fetch address
`timescale 1ns/1ps
module mdt_pmem_model
	import mdt_pkg::*;
(
	input wire logic [PC_W-1:0] i_addr,
	output logic [INSTR_W-1:0] o_word
);
	// Filled by the bench before reset is released; no wait states
	logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1];

	assign o_word = mem[i_addr];
endmodule

// ---- testbench/mdt_decode_props.sv ----
// Port-level assertions for the instruction decode block
`timescale 1ns/1ps
module mdt_decode_props
	import mdt_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [INSTR_W-1:0] i_instr,
	input wire logic [ADDR_W-1:0] i_sw_addr,
	input wire logic [DATA_W-1:0] i_sw_wdata,
	input wire logic i_sw_wr,
	input wire logic i_sw_rd,
	input wire logic [DATA_W-1:0] o_sw_rdata,
	input wire logic [PC_W-1:0] o_pc,
	input wire logic [DATA_W-1:0] o_acc,
	input wire logic o_exec,
	input wire logic o_two_cycle,
	input wire logic o_sleep,
	input wire logic o_wdt_clear,
	input wire logic o_int_en
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);

	// ************************************************************
	// Instruction cycle timing
	// ************************************************************
	property p_exec_gap;
		o_exec |=> !o_exec;
	endproperty
	a_exec_gap: assert property (p_exec_gap)
		else $error("execute pulse longer than one clock");

	// A one-cycle instruction other than sleep moves the counter by exactly one
	property p_pc_step;
		o_exec && !o_two_cycle && !o_sleep |-> o_pc == $past(o_pc, 2) + 10'h001;
	endproperty
	a_pc_step: assert property (p_pc_step)
		else $error("counter did not advance by one");

	property p_next_exec;
		o_exec && !o_two_cycle && !o_sleep |-> ##1 !o_exec ##1 o_exec;
	endproperty
	a_next_exec: assert property (p_next_exec)
		else $error("next instruction not two clocks later");

	property p_pc_hold;
		!o_exec |-> $stable(o_pc);
	endproperty
	a_pc_hold: assert property (p_pc_hold)
		else $error("counter moved without an execute");

	property p_flush_len;
		$rose(o_two_cycle) |-> o_exec ##1 (o_two_cycle && !o_exec)
			##1 (!o_two_cycle && !o_exec);
	endproperty
	a_flush_len: assert property (p_flush_len)
		else $error("flush cycle not two clocks without execute");

	property p_after_flush;
		$fell(o_two_cycle) |-> !o_exec ##1 !o_exec ##1 o_exec;
	endproperty
	a_after_flush: assert property (p_after_flush)
		else $error("target not executed one cycle after flush");

	// ************************************************************
	// Power-down, watchdog and software read port
	// ************************************************************
	property p_sleep_halt;
		o_sleep |=> o_sleep && !o_exec && $stable(o_pc);
	endproperty
	a_sleep_halt: assert property (p_sleep_halt)
		else $error("core kept running after sleep");

	property p_sleep_entry;
		$rose(o_sleep) |-> o_exec && o_wdt_clear && !o_two_cycle;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("sleep entered without watchdog clear");

	property p_wdt_pulse;
		o_wdt_clear |-> o_exec ##1 !o_wdt_clear;
	endproperty
	a_wdt_pulse: assert property (p_wdt_pulse)
		else $error("watchdog clear pulse malformed");

	property p_rd_idle;
		!$past(i_sw_rd) |-> o_sw_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its cycle");

	c_flush: cover property ($rose(o_two_cycle));
	c_sleep: cover property ($rose(o_sleep));
	c_wdt: cover property (o_wdt_clear && !o_sleep);
	c_read: cover property (i_sw_rd ##1 o_sw_rdata != 8'h00);
endmodule

bind mdt_decode mdt_decode_props u_props (
	.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_instr(i_instr),
	.i_sw_addr(i_sw_addr), .i_sw_wdata(i_sw_wdata), .i_sw_wr(i_sw_wr),
	.i_sw_rd(i_sw_rd), .o_sw_rdata(o_sw_rdata), .o_pc(o_pc),
	.o_acc(o_acc), .o_exec(o_exec), .o_two_cycle(o_two_cycle),
	.o_sleep(o_sleep), .o_wdt_clear(o_wdt_clear), .o_int_en(o_int_en)
);

// ---- testbench/testbench.sv ----
// Self-checking bench running a short program through the decode block
`timescale 1ns/1ps
module testbench
	import mdt_pkg::*;
;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [ADDR_W-1:0] i_sw_addr = 8'h00;
	logic [DATA_W-1:0] i_sw_wdata = 8'h00;
	logic i_sw_wr = 1'b0;
	logic i_sw_rd = 1'b0;
	logic [INSTR_W-1:0] i_instr;
	logic [DATA_W-1:0] o_sw_rdata;
	logic [PC_W-1:0] o_pc;
	logic [DATA_W-1:0] o_acc;
	logic o_exec;
	logic o_two_cycle;
	logic o_sleep;
	logic o_wdt_clear;
	logic o_int_en;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int arr [0:1023];
	logic [DATA_W-1:0] acc_at [0:1023];

	always #20 i_core_clk = ~i_core_clk;

	mdt_decode uut (
		.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_instr(i_instr),
		.i_sw_addr(i_sw_addr), .i_sw_wdata(i_sw_wdata), .i_sw_wr(i_sw_wr),
		.i_sw_rd(i_sw_rd), .o_sw_rdata(o_sw_rdata), .o_pc(o_pc),
		.o_acc(o_acc), .o_exec(o_exec), .o_two_cycle(o_two_cycle),
		.o_sleep(o_sleep), .o_wdt_clear(o_wdt_clear), .o_int_en(o_int_en)
	);

	mdt_pmem_model pmem (
		.i_addr(o_pc),
		.o_word(i_instr)
	);

	// First arrival clock and accumulator at each fetch address
	always @(posedge i_core_clk) begin
		if (arr[o_pc] < 0) begin
			arr[o_pc] = cyc;
			acc_at[o_pc] = o_acc;
		end
		cyc = cyc + 1;
	end

	// ************************************************************
	// Access tasks
	// ************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_sw_rd <= 1'b0;
		i_sw_wr <= 1'b1;
		i_sw_addr <= a;
		i_sw_wdata <= d;
	endtask

	task automatic sw_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_core_clk);
		i_sw_wr <= 1'b0;
		i_sw_rd <= 1'b1;
		i_sw_addr <= a;
		@(posedge i_core_clk);
		i_sw_rd <= 1'b0;
		@(negedge i_core_clk);
		check({8'h00, o_sw_rdata}, {8'h00, e});
	endtask

	task automatic ld(input int a, input logic [12:0] w);
		pmem.mem[a] = w;
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Clock distances assume each instruction cycle is two clocks
	task automatic final_checks;
		repeat (10) @(posedge i_core_clk);
		check(16'(o_pc), 16'h0034);
		check(16'(o_acc), 16'h0077);
		check(16'(o_int_en), 16'h0001);
		check(16'(arr[6] - arr[4]), 16'd4);
		check(16'(arr[8] - arr[6]), 16'd2);
		check(16'(arr[9] - arr[8]), 16'd4);
		check(16'(arr[7]), 16'hffff);
		check(16'(arr[15]), 16'hffff);
		check(16'(arr[17] - arr[16]), 16'd4);
		check(16'(arr[18]), 16'hffff);
		check(16'(arr[32] - arr[17]), 16'd2);
		check(16'(arr[48] - arr[32]), 16'd4);
		check(16'(arr[12] - arr[64]), 16'd4);
		check(16'(arr[52] - arr[4]), 16'd46);
		check(16'(acc_at[6]), 16'h0005);
		check(16'(acc_at[9]), 16'h0002);
		sw_rd(8'h10, 8'h11);
		sw_rd(8'h11, 8'h00);
		sw_rd(8'h12, 8'h03);
		sw_rd(8'h13, 8'h80);
		sw_rd(8'h14, 8'h40);
		sw_rd(8'h50, 8'h77);
		sw_rd(8'h04, 8'h40);
		sw_rd(8'h03, 8'h12);
		sw_rd(8'h02, 8'h34);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		for (int i = 0; i < 1024; i++) begin
			arr[i] = -1;
			pmem.mem[i] = 13'h0000;
		end
		ld(4, 13'h1805);
		ld(5, 13'h03d0);
		ld(6, 13'h05d1);
		ld(7, 13'h0a13);
		ld(8, 13'h0592);
		ld(9, 13'h0bd3);
		ld(10, 13'h0654);
		ld(11, 13'h1040);
		ld(12, 13'h0004);
		ld(13, 13'h0020);
		ld(15, 13'h0a13);
		ld(16, 13'h1820);
		ld(17, 13'h0042);
		ld(32, 13'h1430);
		ld(48, 13'h1840);
		ld(49, 13'h0044);
		ld(50, 13'h1877);
		ld(51, 13'h0050);
		ld(52, 13'h0003);
		ld(64, 13'h0013);
		repeat (12) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		// Operands must land before the leading no-ops run out
		sw_wr(8'h10, 8'h0c);
		sw_wr(8'h11, 8'h01);
		sw_wr(8'h12, 8'h03);
		sw_wr(8'h13, 8'h00);
		sw_wr(8'h14, 8'h81);
		sw_wr(8'h02, 8'h55);
		sw_rd(8'h03, 8'h18);
		sw_rd(8'h04, 8'h00);
		for (int n = 0; n < 400 && o_sleep !== 1'b1; n++) begin
			@(posedge i_core_clk);
		end
		if (o_sleep !== 1'b1) begin
			fail_count++;
			$display("MISMATCH t=%0t core never reached sleep", $time);
		end else begin
			final_checks();
		end
		results();
	end
endmodule
